//--- hw/time_manager_node.sv
`timescale 1ns/1ps
`default_nettype none
`include "time_manager_cfg.svh"

module time_manager_node #(
  parameter int unsigned TICK_CYCLES = `TM_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Navigation receiver pins
  input wire logic second_pulse,
  input wire logic megahertz_pulse,
  input wire logic receiver_lock,
  input wire logic [31:0] atomic_time,
  // Commands
  input wire logic cmd_commission,
  input wire logic cmd_epoch_load,
  input wire logic [31:0] cmd_epoch,
  input wire logic cmd_start,
  input wire logic auto_sync_enable,
  // Distribution toward user nodes
  output logic time_code_valid,
  output logic [5:0] time_code,
  output logic second_write_valid,
  output logic [31:0] second_write_data,
  // Status
  output logic [37:0] time_indicator,
  output time_manager_pkg::time_mode_t mode,
  output logic internal_second_pulse
);

  localparam logic [20:0] TICK_LAST = 21'(TICK_CYCLES - 1);
  localparam logic [20:0] STRETCH = 21'(`TM_STRETCH_CYCLES);
  localparam logic [26:0] ALIGN = 27'(`TM_ALIGN_CYCLES);
  localparam logic [8:0] MHZ_TIMEOUT = 9'(`TM_MHZ_TIMEOUT_CYCLES);

  // ----------------------------------------
  // Receiver inputs
  // ----------------------------------------
  logic [2:0] pin_level;
  logic [2:0] pin_rise;
  logic [31:0] atomic_meta;
  logic [31:0] atomic_sync;
  logic [31:0] next_atomic_meta;
  logic [31:0] next_atomic_sync;
  logic rx_second;
  logic lock_level;
  logic mhz_rise;

  pin_sync #(.WIDTH(3)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin({receiver_lock, megahertz_pulse, second_pulse}),
    .level(pin_level),
    .rise(pin_rise)
  );

  assign rx_second = pin_rise[0];
  assign mhz_rise = pin_rise[1];
  assign lock_level = pin_level[2];

  // Time word is settled well before the pulse, so a plain two-stage copy is enough
  always_comb begin
    next_atomic_meta = atomic_time;
    next_atomic_sync = atomic_meta;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      atomic_meta <= '0;
      atomic_sync <= '0;
    end else begin
      atomic_meta <= next_atomic_meta;
      atomic_sync <= next_atomic_sync;
    end
  end

  // ----------------------------------------
  // Receiver health
  // ----------------------------------------
  // Lock alone is not trusted: a dead megahertz train drops the lock too
  logic [8:0] mhz_idle;
  logic [8:0] next_mhz_idle;
  logic lock_ok;

  always_comb begin
    if (mhz_rise) begin
      next_mhz_idle = '0;
    end else if (mhz_idle != MHZ_TIMEOUT) begin
      next_mhz_idle = mhz_idle + 9'h001;
    end else begin
      next_mhz_idle = mhz_idle;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mhz_idle <= MHZ_TIMEOUT;
    end else begin
      mhz_idle <= next_mhz_idle;
    end
  end

  assign lock_ok = lock_level && (mhz_idle != MHZ_TIMEOUT) && auto_sync_enable;

  // ----------------------------------------
  // Mode and time indicator
  // ----------------------------------------
  time_manager_pkg::time_mode_t next_mode;
  logic [37:0] next_time_indicator;
  logic [20:0] tick_cnt;
  logic [20:0] next_tick_cnt;
  logic [26:0] phase_cnt;
  logic [26:0] next_phase_cnt;
  logic [26:0] rx_since;
  logic [26:0] next_rx_since;
  logic [20:0] tick_limit;
  logic running;
  logic in_sync;
  logic tick_end;
  logic sec_boundary;
  logic code_event;
  logic aligned;
  logic [5:0] sub;
  logic [31:0] seconds;

  assign sub = time_indicator[`TM_SUB_BITS-1:0];
  assign seconds = time_indicator[`TM_TI_BITS-1:`TM_SUB_BITS];
  assign running = (mode == time_manager_pkg::MODE_UNSYNC) ||
                   (mode == time_manager_pkg::MODE_TRANSITION) ||
                   (mode == time_manager_pkg::MODE_SYNC);
  assign in_sync = (mode == time_manager_pkg::MODE_SYNC);

  assign tick_limit = (mode == time_manager_pkg::MODE_TRANSITION) ? TICK_LAST + STRETCH : TICK_LAST;
  // A fallback out of a stretched tick can leave the count past the shorter limit
  assign tick_end = running && (tick_cnt >= tick_limit);
  assign sec_boundary = in_sync ? rx_second : (tick_end && (sub == `TM_SUB_LAST));
  assign code_event = in_sync ? (rx_second || (tick_end && (sub != `TM_SUB_LAST))) : tick_end;
  assign aligned = (rx_second && (phase_cnt < ALIGN)) || (sec_boundary && (rx_since < ALIGN));

  always_comb begin
    next_mode = mode;
    next_time_indicator = time_indicator;
    next_tick_cnt = tick_cnt;
    next_phase_cnt = (phase_cnt == '1) ? phase_cnt : phase_cnt + 27'h000_0001;
    next_rx_since = (rx_since == '1) ? rx_since : rx_since + 27'h000_0001;
    if (sec_boundary) begin
      next_phase_cnt = '0;
    end
    if (rx_second) begin
      next_rx_since = '0;
    end
    if (running) begin
      if (tick_end) begin
        next_tick_cnt = '0;
      end else if (tick_cnt != tick_limit) begin
        next_tick_cnt = tick_cnt + 21'h00_0001;
      end
    end
    if (in_sync && rx_second) begin
      next_time_indicator = {atomic_sync, `TM_SUB_ZERO};
      next_tick_cnt = '0;
    end else if (tick_end && !(in_sync && (sub == `TM_SUB_LAST))) begin
      next_time_indicator = time_indicator + 38'h00_0000_0001;
    end
    case (mode)
      time_manager_pkg::MODE_POWER_ON: begin
        if (cmd_commission) begin
          next_mode = time_manager_pkg::MODE_TIME_INITIAL;
        end
      end
      time_manager_pkg::MODE_TIME_INITIAL: begin
        if (cmd_epoch_load) begin
          next_time_indicator = {cmd_epoch, `TM_SUB_ZERO};
          next_tick_cnt = '0;
        end
        if (cmd_start) begin
          next_mode = time_manager_pkg::MODE_UNSYNC;
        end
      end
      time_manager_pkg::MODE_UNSYNC: begin
        if (cmd_epoch_load) begin
          next_time_indicator = {cmd_epoch, `TM_SUB_ZERO};
          next_tick_cnt = '0;
        end
        if (lock_ok) begin
          next_mode = time_manager_pkg::MODE_TRANSITION;
        end
      end
      time_manager_pkg::MODE_TRANSITION: begin
        if (!lock_ok) begin
          next_mode = time_manager_pkg::MODE_UNSYNC;
        end else if (aligned) begin
          next_mode = time_manager_pkg::MODE_SYNC;
        end
      end
      time_manager_pkg::MODE_SYNC: begin
        if (!lock_ok) begin
          next_mode = time_manager_pkg::MODE_UNSYNC;
        end
      end
      default: begin
        next_mode = time_manager_pkg::MODE_POWER_ON;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode <= time_manager_pkg::MODE_POWER_ON;
      time_indicator <= `TM_TI_RESET;
      tick_cnt <= '0;
      phase_cnt <= '0;
      rx_since <= '1;
    end else begin
      mode <= next_mode;
      time_indicator <= next_time_indicator;
      tick_cnt <= next_tick_cnt;
      phase_cnt <= next_phase_cnt;
      rx_since <= next_rx_since;
    end
  end

  // ----------------------------------------
  // Distribution
  // ----------------------------------------
  // Only one link port exists; the attitude network gets nothing from here.
  // no attitude distribution
  logic next_time_code_valid;
  logic [5:0] next_time_code;
  logic next_second_write_valid;
  logic [31:0] next_second_write_data;
  logic write_pending;
  logic next_write_pending;
  logic next_internal_second_pulse;

  always_comb begin
    next_time_code_valid = code_event;
    next_time_code = next_time_indicator[`TM_SUB_BITS-1:0];
    next_internal_second_pulse = sec_boundary;
    next_second_write_data = second_write_data;
    next_write_pending = write_pending || sec_boundary;
    next_second_write_valid = 1'b0;
    if (sec_boundary) begin
      next_second_write_data = next_time_indicator[`TM_TI_BITS-1:`TM_SUB_BITS];
    end
    if (next_write_pending && !code_event) begin
      next_second_write_valid = 1'b1;
      next_write_pending = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      time_code_valid <= 1'b0;
      time_code <= `TM_SUB_ZERO;
      second_write_valid <= 1'b0;
      second_write_data <= '0;
      write_pending <= 1'b0;
      internal_second_pulse <= 1'b0;
    end else begin
      time_code_valid <= next_time_code_valid;
      time_code <= next_time_code;
      second_write_valid <= next_second_write_valid;
      second_write_data <= next_second_write_data;
      write_pending <= next_write_pending;
      internal_second_pulse <= next_internal_second_pulse;
    end
  end

endmodule

`default_nettype wire

//--- hw/time_manager_cfg.svh
// Contract
// - The node is the root master of the tree network and the only time source for user nodes.
// - Whole seconds go out as a memory-write word and the sub-second part as time codes.
// - Time codes go ahead of every other traffic on the link.
// - The node has exactly five modes: power-on, time initial, unsynchronized, transition, synced.
// - When synchronized the time indicator follows atomic time, second for second.
// - Lock-on first passes through transition, where seconds are stretched until aligned.
// - When unsynchronized the node counts from its own quartz, epoch default or loaded.
// - Time initial loads the epoch by command; power-on and time initial are commissioning only.
// - No time writes or time codes go into the attitude-control network.
// - The time indicator is a 38-bit count of 1/64 s: 32 bits of seconds, 6 bits of ticks.
// - Transition ends once the internal and receiver second pulses differ by under 1 us.
`ifndef TIME_MANAGER_CFG_SVH
`define TIME_MANAGER_CFG_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define TM_CLK_NS 8
`define TM_TICK_NS 15625000
`define TM_TICK_CYCLES (`TM_TICK_NS / `TM_CLK_NS)
`define TM_STRETCH_NS 1000
`define TM_STRETCH_CYCLES ((`TM_STRETCH_NS + `TM_CLK_NS - 1) / `TM_CLK_NS)
`define TM_ALIGN_NS 1000
`define TM_ALIGN_CYCLES (`TM_ALIGN_NS / `TM_CLK_NS)
`define TM_MHZ_TIMEOUT_NS 2000
`define TM_MHZ_TIMEOUT_CYCLES (`TM_MHZ_TIMEOUT_NS / `TM_CLK_NS)

// ----------------------------------------
// Time indicator layout
// ----------------------------------------
`define TM_TI_BITS 38
`define TM_SUB_BITS 6
`define TM_SEC_BITS 32
`define TM_SUB_LAST 6'h3f
`define TM_SUB_ZERO 6'h00
`define TM_TI_RESET 38'h00_0000_0000

`endif

//--- hw/time_manager_pkg.sv
package time_manager_pkg;

  typedef enum logic [2:0] {
    MODE_POWER_ON,
    MODE_TIME_INITIAL,
    MODE_UNSYNC,
    MODE_TRANSITION,
    MODE_SYNC
  } time_mode_t;

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Asynchronous pins
  input wire logic [WIDTH-1:0] pin,
  // Synchronised level and rising edge
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_level;
  logic [WIDTH-1:0] next_prev;

  // Edge detect looks only at the second stage and later
  always_comb begin
    next_meta = pin;
    next_level = meta;
    next_prev = level;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= '0;
      level <= '0;
      prev <= '0;
    end else begin
      meta <= next_meta;
      level <= next_level;
      prev <= next_prev;
    end
  end

  assign rise = level & ~prev;

endmodule

`default_nettype wire

//--- testbench/time_manager_chk.sv
`timescale 1ns/1ps
`default_nettype none

module time_manager_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Receiver and commands
  input wire logic second_pulse,
  input wire logic megahertz_pulse,
  input wire logic receiver_lock,
  input wire logic [31:0] atomic_time,
  input wire logic cmd_commission,
  input wire logic cmd_epoch_load,
  input wire logic [31:0] cmd_epoch,
  input wire logic cmd_start,
  input wire logic auto_sync_enable,
  // Distribution and status
  input wire logic time_code_valid,
  input wire logic [5:0] time_code,
  input wire logic second_write_valid,
  input wire logic [31:0] second_write_data,
  input wire logic [37:0] time_indicator,
  input var time_manager_pkg::time_mode_t mode,
  input wire logic internal_second_pulse
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_new_second;
    time_code_valid && time_code == 6'h00;
  endsequence
  sequence s_write;
    second_write_valid && second_write_data == time_indicator[37:6];
  endsequence
  property p_code_pulse; time_code_valid |=> !time_code_valid; endproperty
  a_code_pulse: assert property (p_code_pulse)
    else $error("time code longer than one cycle");
  property p_second_write; s_new_second |=> s_write; endproperty
  a_second_write: assert property (p_second_write)
    else $error("second write missing after code zero");
  property p_write_cause;
    second_write_valid |-> $past(time_code_valid) && $past(time_code) == 6'h00;
  endproperty
  a_write_cause: assert property (p_write_cause)
    else $error("second write without preceding code zero");
  property p_layout; time_code_valid |-> time_indicator[5:0] == time_code; endproperty
  a_layout: assert property (p_layout)
    else $error("time code differs from indicator ticks");
  property p_int_second; internal_second_pulse |-> s_new_second; endproperty
  a_int_second: assert property (p_int_second)
    else $error("internal second off the tick zero");
  property p_five_modes;
    mode inside {time_manager_pkg::MODE_POWER_ON, time_manager_pkg::MODE_TIME_INITIAL,
      time_manager_pkg::MODE_UNSYNC, time_manager_pkg::MODE_TRANSITION,
      time_manager_pkg::MODE_SYNC};
  endproperty
  a_five_modes: assert property (p_five_modes)
    else $error("illegal mode value");
  property p_via_transition;
    $changed(mode) && mode == time_manager_pkg::MODE_SYNC
      |-> $past(mode) == time_manager_pkg::MODE_TRANSITION;
  endproperty
  a_via_transition: assert property (p_via_transition)
    else $error("sync entered without transition");
  property p_lock_needed;
    mode == time_manager_pkg::MODE_TRANSITION && $past(mode) == time_manager_pkg::MODE_UNSYNC
      |-> $past(auto_sync_enable) || $past(auto_sync_enable, 2);
  endproperty
  a_lock_needed: assert property (p_lock_needed)
    else $error("transition entered with sync disabled");
  property p_commission_only;
    $past(mode) inside {time_manager_pkg::MODE_UNSYNC, time_manager_pkg::MODE_TRANSITION,
      time_manager_pkg::MODE_SYNC} |-> mode inside {time_manager_pkg::MODE_UNSYNC,
      time_manager_pkg::MODE_TRANSITION, time_manager_pkg::MODE_SYNC};
  endproperty
  a_commission_only: assert property (p_commission_only)
    else $error("return to commissioning mode");
  property p_no_jump;
    mode == time_manager_pkg::MODE_UNSYNC && $past(mode) inside
      {time_manager_pkg::MODE_TRANSITION, time_manager_pkg::MODE_SYNC}
      |-> time_indicator - $past(time_indicator) <= 38'h1;
  endproperty
  a_no_jump: assert property (p_no_jump)
    else $error("indicator jumped on fallback");
endmodule

`default_nettype wire

//--- testbench/nav_receiver_model.sv
`timescale 1ns/1ps
`default_nettype none

module nav_receiver_model #(
  parameter int SEC_NS = 102400
) (
  // Lock request from the bench
  input wire logic lock_req,
  // Receiver pins
  output logic second_pulse,
  output logic megahertz_pulse,
  output logic receiver_lock,
  output logic [31:0] atomic_time
);
  // ----------------------------------------
  // Pulse trains and time word
  // ----------------------------------------
  initial begin
    second_pulse = 1'b0;
    megahertz_pulse = 1'b0;
    atomic_time = 32'h0000_0100;
  end
  always #500 megahertz_pulse = ~megahertz_pulse;
  // word settles well before its pulse
  always begin
    #(SEC_NS - 200);
    atomic_time = atomic_time + 32'h1;
    #100 second_pulse = 1'b1;
    #100 second_pulse = 1'b0;
  end
  int telemetry_bytes = 0;
  always @(posedge second_pulse) telemetry_bytes = telemetry_bytes + 8192;
  assign receiver_lock = lock_req;
endmodule

`default_nettype wire

//--- testbench/spacecraft_time_mode_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module spacecraft_time_mode_manager_tb_top;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  localparam int TICK = 200;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic lock_req = 1'b0;
  logic second_pulse, megahertz_pulse, receiver_lock;
  logic [31:0] atomic_time;
  logic cmd_commission = 1'b0, cmd_epoch_load = 1'b0, cmd_start = 1'b0;
  logic auto_sync_enable = 1'b0;
  logic [31:0] cmd_epoch = 32'h0;
  logic time_code_valid, second_write_valid, internal_second_pulse;
  logic [5:0] time_code;
  logic [31:0] second_write_data;
  logic [37:0] time_indicator, last_exp = 38'h0;
  logic [37:0] exp_q[$];
  time_manager_pkg::time_mode_t mode, code_mode = time_manager_pkg::MODE_POWER_ON;
  int failures = 0, total_checks = 0, gap = 0;

  always #4 clk_sys = ~clk_sys;

  nav_receiver_model #(.SEC_NS(64 * TICK * 8)) rx (.lock_req, .second_pulse,
    .megahertz_pulse, .receiver_lock, .atomic_time);
  time_manager_node #(.TICK_CYCLES(TICK)) uut (.clk_sys, .rst, .second_pulse,
    .megahertz_pulse, .receiver_lock, .atomic_time, .cmd_commission, .cmd_epoch_load,
    .cmd_epoch, .cmd_start, .auto_sync_enable, .time_code_valid, .time_code,
    .second_write_valid, .second_write_data, .time_indicator, .mode, .internal_second_pulse);

  task automatic chk(input string name, input logic [37:0] e, input logic [37:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_mode(input time_manager_pkg::time_mode_t m);
    for (int i = 0; i < 300 && mode !== m; i++) @(negedge clk_sys);
    chk("mode", 38'(m), 38'(mode));
    if (mode !== m) complete_run();
  endtask

  // Bounded: a stalled tick counter ends the run
  task automatic wait_queue(input int left);
    for (int i = 0; i < 30000 && exp_q.size() > left; i++) @(negedge clk_sys);
    if (exp_q.size() > left) begin
      failures++;
      complete_run();
    end
  endtask

  // Monitor takes the oldest expected indicator at each time code, sampled settled
  always @(negedge clk_sys) begin
    gap++;
    if (!rst && time_code_valid) begin
      if (exp_q.size() == 0) chk("queue_depth", 38'h1, 38'h0);
      else begin
        last_exp = exp_q.pop_front();
        chk("time_indicator", last_exp, time_indicator);
        chk("time_code", 38'(last_exp[5:0]), 38'(time_code));
      end
      if (mode === code_mode && mode inside {time_manager_pkg::MODE_UNSYNC,
          time_manager_pkg::MODE_TRANSITION})
        chk("tick_gap", (mode == time_manager_pkg::MODE_UNSYNC) ? 38'(TICK) :
          38'(TICK + 125), 38'(gap));
      code_mode = mode;
      gap = 0;
    end
    if (!rst && second_write_valid)
      chk("second_write_data", 38'(last_exp[37:6]), 38'(second_write_data));
  end

  initial begin
    void'($urandom(44299));
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    cmd_epoch = $urandom;
    cmd_epoch_load = 1'b1;
    cmd_start = 1'b1;
    @(negedge clk_sys);
    cmd_epoch_load = 1'b0;
    cmd_start = 1'b0;
    @(negedge clk_sys);
    chk("mode", 38'(time_manager_pkg::MODE_POWER_ON), 38'(mode));
    chk("time_indicator", 38'h0, time_indicator);
    cmd_commission = 1'b1;
    @(negedge clk_sys);
    cmd_commission = 1'b0;
    cmd_epoch = 32'hffff_ffff;
    cmd_epoch_load = 1'b1;
    @(negedge clk_sys);
    cmd_epoch_load = 1'b0;
    @(negedge clk_sys);
    chk("mode", 38'(time_manager_pkg::MODE_TIME_INITIAL), 38'(mode));
    chk("time_indicator", {32'hffff_ffff, 6'h00}, time_indicator);
    cmd_start = 1'b1;
    // Epoch at the top forces a seconds wrap
    for (int k = 1; k <= 104; k++) exp_q.push_back({32'hffff_ffff, 6'h00} + 38'(k));
    @(negedge clk_sys);
    cmd_start = 1'b0;
    @(negedge clk_sys);
    chk("mode", 38'(time_manager_pkg::MODE_UNSYNC), 38'(mode));
    wait_queue(34);
    lock_req = 1'b1;
    auto_sync_enable = 1'b1;
    wait_mode(time_manager_pkg::MODE_TRANSITION);
    wait_queue(30);
    auto_sync_enable = 1'b0;
    wait_mode(time_manager_pkg::MODE_UNSYNC);
    wait_queue(0);
    repeat (3) @(negedge clk_sys);
    complete_run();
  end
endmodule

bind time_manager_node time_manager_chk u_chk (.clk_sys, .rst, .second_pulse,
  .megahertz_pulse, .receiver_lock, .atomic_time, .cmd_commission, .cmd_epoch_load,
  .cmd_epoch, .cmd_start, .auto_sync_enable, .time_code_valid, .time_code,
  .second_write_valid, .second_write_data, .time_indicator, .mode, .internal_second_pulse);

`default_nettype wire
